/* common/ffc_map.svh */
// What this block does
// - output equals raw times target over flat
// - enable 0 bypasses, 1 applies correction while idle or saving, bypasses during generate and load
// - slot selector takes values 0 to 15
// - generate with zero derives target automatically
// - generate with 1..4095 uses it as target
// - save copies active data into selected slot
// - generated data volatile, lost at reset
// - load copies selected slot into active data
// - generate samples the next single full frame
// - flat data bilinearly enlarged before dividing
// - load before save discards generated data
// - active data is a single set shared by all slots
// - active data, not the selected slot's data, is what corrects pixels
`ifndef FFC_MAP_SVH
`define FFC_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define FFC_REG_CTRL    8'h00
`define FFC_REG_SLOT    8'h04
`define FFC_REG_TARGET  8'h08
`define FFC_REG_GEN     8'h0c
`define FFC_REG_SAVE    8'h10
`define FFC_REG_LOAD    8'h14
`define FFC_REG_STATUS  8'h18

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define FFC_CTRL_EN     0
`define FFC_ST_BUSY     0
`define FFC_ST_WAITFRM  1
`define FFC_ST_UNSAVED  2
`define FFC_PIX_W       12
`define FFC_SLOT_W      4
`define FFC_NV_IDX_W    5

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define FFC_PIX_MAX     12'hfff
`define FFC_FLAT_RST    12'hfff
`define FFC_TARGET_RST  12'hfff
`define FFC_SLOT_RST    4'h0

`endif

/* common/ffc_pkg.sv */
`default_nettype none
package ffc_pkg;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_GEN_WAIT,
		ST_GEN_RUN,
		ST_SAVE,
		ST_LOAD,
		ST_LOAD_TAIL
	} seq_state_t;

endpackage
`default_nettype wire

/* verilog/ffc_fifo.sv */
`default_nettype none
module ffc_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 4
) (
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic             inValid,
	output var  logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output var  logic             outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULLC = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LASTP = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp;
	logic [AW-1:0]    rp;
	logic [AW:0]      count;
	logic             push;
	logic             pop;
	logic [AW:0]      next_count;

	// handshakes on both sides
	assign push = inValid & inReady;
	assign pop = outValid & outReady;
	assign outData = mem[rp];

	always_comb begin
		next_count = count;
		if (push && !pop)
			next_count = count + 1'b1;
		else if (pop && !push)
			next_count = count - 1'b1;
	end

	// storage write
	always_ff @(posedge mclk) begin
		if (push)
			mem[wp] <= inData;
	end

	// pointers, occupancy and flags held in flops
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
			inReady <= 1'b0;
			outValid <= 1'b0;
		end else begin
			if (push)
				wp <= (wp == LASTP) ? '0 : wp + 1'b1;
			if (pop)
				rp <= (rp == LASTP) ? '0 : rp + 1'b1;
			count <= next_count;
			inReady <= (next_count != FULLC);
			outValid <= (next_count != '0);
		end
	end

endmodule
`default_nettype wire

/* verilog/flat_field_correction.sv */
`include "ffc_map.svh"
`default_nettype none
module flat_field_correction
	import ffc_pkg::*;
#(
	parameter int IMG_W   = 1024,
	parameter int IMG_H   = 1024,
	parameter int CELL_SH = 8,
	parameter int FIFO_D  = 4
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output var  logic [31:0] regRdData,
	// raw pixel stream
	input  wire logic        pixInValid,
	output var  logic        pixInReady,
	input  wire logic        pixInSof,
	input  wire logic [11:0] rawLevel,
	// corrected pixel stream
	output var  logic        pixOutValid,
	input  wire logic        pixOutReady,
	output var  logic        pixOutSof,
	output var  logic [11:0] correctedLevel,
	// non-volatile store port, read data one cycle after nvRd
	output var  logic [8:0]  nvAddr,
	output var  logic [11:0] nvWrData,
	output var  logic        nvWr,
	output var  logic        nvRd,
	input  wire logic [11:0] nvRdData
);
	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int GX    = (IMG_W >> CELL_SH) + 1;
	localparam int GY    = (IMG_H >> CELL_SH) + 1;
	localparam int NPTS  = GX * GY;
	localparam int PIXSH = $clog2(IMG_W * IMG_H);
	localparam logic [15:0] LASTX = 16'(IMG_W - 1);
	localparam logic [15:0] LASTY = 16'(IMG_H - 1);
	localparam logic [9:0]  SCALE = 10'(1 << CELL_SH);
	localparam logic [`FFC_NV_IDX_W-1:0] TGT_IDX = `FFC_NV_IDX_W'(NPTS);

	// grid column or row index of a coordinate lying on a grid line
	function automatic logic [7:0] ptIndex(input logic [15:0] c);
		ptIndex = 8'((32'(c) + (1 << CELL_SH) - 1) >> CELL_SH);
	endfunction

	// coordinate lies on a sampling line, last line clamped to the edge
	function automatic logic ptHit(input logic [15:0] c, input logic [15:0] last);
		ptHit = (c[CELL_SH-1:0] == '0) || (c == last);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	seq_state_t              state;
	logic                    corrEn;
	logic [`FFC_SLOT_W-1:0]  slot;
	logic [11:0]             target;
	logic [11:0]             genArg;
	logic                    unsaved;
	logic [11:0]             flat [NPTS];
	logic [`FFC_NV_IDX_W-1:0] xferIdx;
	logic [`FFC_NV_IDX_W-1:0] ldIdx;
	logic                    ldValid;
	logic [31:0]             frameSum;
	logic [15:0]             nextX;
	logic [15:0]             nextY;

	logic                    fifoValid;
	logic                    fifoReady;
	logic [12:0]             fifoData;
	logic                    adv;
	logic                    pop;
	logic                    popSof;
	logic [11:0]             popRaw;
	logic [15:0]             curX;
	logic [15:0]             curY;
	logic                    lastPix;
	logic                    genTake;
	logic [31:0]             next_sum;
	logic [11:0]             frameMean;
	logic                    idle;
	logic                    wrGen;
	logic                    wrSave;
	logic                    wrLoad;
	logic                    wrSlot;

	logic                    s1Valid;
	logic                    s1Sof;
	logic                    s1Byp;
	logic [11:0]             s1Raw;
	logic [11:0]             s1Flat;
	logic [11:0]             interpFlat;
	logic [11:0]             next_level;

	// ----------------------------------------------------------------
	// input buffer
	// ----------------------------------------------------------------
	ffc_fifo #(
		.WIDTH (13),
		.DEPTH (FIFO_D)
	) u_fifo (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.inValid  (pixInValid),
		.inReady  (pixInReady),
		.inData   ({pixInSof, rawLevel}),
		.outValid (fifoValid),
		.outReady (fifoReady),
		.outData  (fifoData)
	);

	// pipeline moves when the output slot is free or being taken
	assign adv = !pixOutValid || pixOutReady;
	assign fifoReady = adv;
	assign pop = fifoValid & adv;
	assign popSof = fifoData[12];
	assign popRaw = fifoData[11:0];
	assign curX = popSof ? 16'h0000 : nextX;
	assign curY = popSof ? 16'h0000 : nextY;
	assign lastPix = (curX == LASTX) && (curY == LASTY);

	// ----------------------------------------------------------------
	// pixel position tracking
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			nextX <= 16'h0000;
			nextY <= 16'h0000;
		end else if (pop) begin
			if (curX == LASTX) begin
				nextX <= 16'h0000;
				nextY <= curY + 16'h0001;
			end else begin
				nextX <= curX + 16'h0001;
				nextY <= curY;
			end
		end
	end

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	assign idle = (state == ST_IDLE);
	assign wrGen = regWr && (regAddr == `FFC_REG_GEN) && idle;
	assign wrSave = regWr && (regAddr == `FFC_REG_SAVE) && idle;
	assign wrLoad = regWr && (regAddr == `FFC_REG_LOAD) && idle;
	assign wrSlot = regWr && (regAddr == `FFC_REG_SLOT);

	// enable bit and slot selector
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			corrEn <= 1'b0;
			slot <= `FFC_SLOT_RST;
		end else begin
			if (regWr && regAddr == `FFC_REG_CTRL)
				corrEn <= regWrData[`FFC_CTRL_EN];
			if (wrSlot && idle)
				slot <= regWrData[`FFC_SLOT_W-1:0];
		end
	end

	// read data one cycle after the strobe, unmapped reads as zero
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			regRdData <= 32'h0000_0000;
		end else if (regRd) begin
			regRdData <= 32'h0000_0000;
			unique case (regAddr)
				`FFC_REG_CTRL:   regRdData[`FFC_CTRL_EN] <= corrEn;
				`FFC_REG_SLOT:   regRdData[`FFC_SLOT_W-1:0] <= slot;
				`FFC_REG_TARGET: regRdData[11:0] <= target;
				`FFC_REG_STATUS: begin
					regRdData[`FFC_ST_BUSY] <= !idle;
					regRdData[`FFC_ST_WAITFRM] <= (state == ST_GEN_WAIT) ||
						(state == ST_GEN_RUN);
					regRdData[`FFC_ST_UNSAVED] <= unsaved;
				end
				default: regRdData <= 32'h0000_0000;
			endcase
		end else begin
			regRdData <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// frame capture for generation
	// ----------------------------------------------------------------
	assign genTake = pop && ((state == ST_GEN_RUN) || (state == ST_GEN_WAIT && popSof));
	assign next_sum = popSof ? 32'(popRaw) : frameSum + 32'(popRaw);
	assign frameMean = 12'(next_sum >> PIXSH);

	always_ff @(posedge mclk) begin
		if (!rst_b)
			frameSum <= 32'h0000_0000;
		else if (genTake)
			frameSum <= next_sum;
	end

	// ----------------------------------------------------------------
	// sequencer: generate, save, load
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			genArg <= 12'h000;
			xferIdx <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					xferIdx <= '0;
					if (wrGen) begin
						genArg <= regWrData[11:0];
						state <= ST_GEN_WAIT;
					end else if (wrSave) begin
						state <= ST_SAVE;
					end else if (wrLoad || (wrSlot && !unsaved)) begin
						state <= ST_LOAD;
					end
				end
				ST_GEN_WAIT: begin
					if (genTake)
						state <= lastPix ? ST_IDLE : ST_GEN_RUN;
				end
				ST_GEN_RUN: begin
					if (genTake && lastPix)
						state <= ST_IDLE;
				end
				ST_SAVE: begin
					xferIdx <= xferIdx + 1'b1;
					if (xferIdx == TGT_IDX)
						state <= ST_IDLE;
				end
				ST_LOAD: begin
					xferIdx <= xferIdx + 1'b1;
					if (xferIdx == TGT_IDX)
						state <= ST_LOAD_TAIL;
				end
				ST_LOAD_TAIL: state <= ST_IDLE;
			endcase
		end
	end

	// unsaved flag: set by a finished capture, cleared by save or load
	always_ff @(posedge mclk) begin
		if (!rst_b)
			unsaved <= 1'b0;
		else if (genTake && lastPix)
			unsaved <= 1'b1;
		else if (state == ST_SAVE || state == ST_LOAD)
			unsaved <= 1'b0;
	end

	// non-volatile store strobes, slot picks the upper address bits
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			nvAddr <= 9'h000;
			nvWrData <= 12'h000;
			nvWr <= 1'b0;
			nvRd <= 1'b0;
		end else begin
			nvAddr <= {slot, xferIdx};
			nvWrData <= (xferIdx == TGT_IDX) ? target : flat[xferIdx];
			nvWr <= (state == ST_SAVE);
			nvRd <= (state == ST_LOAD);
		end
	end

	// load data returns one cycle after the read strobe
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ldIdx <= '0;
			ldValid <= 1'b0;
		end else begin
			ldIdx <= nvAddr[`FFC_NV_IDX_W-1:0];
			ldValid <= nvRd;
		end
	end

	// ----------------------------------------------------------------
	// active flat data and target, volatile
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			for (int i = 0; i < NPTS; i++)
				flat[i] <= `FFC_FLAT_RST;
		end else if (ldValid && ldIdx != TGT_IDX) begin
			flat[ldIdx] <= nvRdData;
		end else if (genTake && ptHit(curX, LASTX) && ptHit(curY, LASTY)) begin
			flat[ptIndex(curY) * GX + ptIndex(curX)] <= popRaw;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b)
			target <= `FFC_TARGET_RST;
		else if (ldValid && ldIdx == TGT_IDX)
			target <= nvRdData;
		else if (genTake && lastPix)
			target <= (genArg == 12'h000) ? frameMean : genArg;
	end

	// ----------------------------------------------------------------
	// bilinear enlargement of the grid at the popped position
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0]  cx;
		logic [7:0]  cy;
		logic [9:0]  fx;
		logic [9:0]  fy;
		logic [21:0] top;
		logic [21:0] bot;
		logic [31:0] mix;
		cx = 8'(curX >> CELL_SH);
		cy = 8'(curY >> CELL_SH);
		fx = 10'(curX[CELL_SH-1:0]);
		fy = 10'(curY[CELL_SH-1:0]);
		top = 22'(flat[cy * GX + cx] * (SCALE - fx)) +
			22'(flat[cy * GX + cx + 1] * fx);
		bot = 22'(flat[(cy + 1) * GX + cx] * (SCALE - fx)) +
			22'(flat[(cy + 1) * GX + cx + 1] * fx);
		mix = 32'(top * (SCALE - fy)) + 32'(bot * fy);
		interpFlat = 12'(mix >> (2 * CELL_SH));
	end

	// stage one: pixel with its enlarged flat value
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s1Valid <= 1'b0;
			s1Sof <= 1'b0;
			s1Byp <= 1'b1;
			s1Raw <= 12'h000;
			s1Flat <= 12'h000;
		end else if (adv) begin
			s1Valid <= pop;
			s1Sof <= popSof;
			s1Byp <= !corrEn || !(idle || state == ST_SAVE);
			s1Raw <= popRaw;
			s1Flat <= interpFlat;
		end
	end

	// ----------------------------------------------------------------
	// correction divide with clamp
	// ----------------------------------------------------------------
	always_comb begin
		logic [23:0] prod;
		logic [23:0] quot;
		prod = s1Raw * target;
		quot = (s1Flat == 12'h000) ? 24'hffffff : prod / 24'(s1Flat);
		if (s1Byp)
			next_level = s1Raw;
		else if (quot > 24'(`FFC_PIX_MAX))
			next_level = `FFC_PIX_MAX;
		else
			next_level = quot[11:0];
	end

	// output stage
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pixOutValid <= 1'b0;
			pixOutSof <= 1'b0;
			correctedLevel <= 12'h000;
		end else if (adv) begin
			pixOutValid <= s1Valid;
			pixOutSof <= s1Sof;
			correctedLevel <= next_level;
		end
	end

endmodule
`default_nettype wire

/* test/ffc_properties.sv */
`default_nettype none
module ffc_properties (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        regRd,
	input wire logic [31:0] regRdData,
	input wire logic        pixOutValid,
	input wire logic        pixOutReady,
	input wire logic        pixOutSof,
	input wire logic [11:0] correctedLevel,
	input wire logic [8:0]  nvAddr,
	input wire logic        nvWr,
	input wire logic        nvRd
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// ----
	// store bursts
	// ----
	logic [5:0] wrRun;
	logic [5:0] rdRun;

	// length of the current write and read runs
	always_ff @(posedge mclk) begin
		wrRun <= (rst_b && nvWr) ? wrRun + 6'h1 : 6'h0;
		rdRun <= (rst_b && nvRd) ? rdRun + 6'h1 : 6'h0;
	end

	property p_saveLen;
		$fell(nvWr) |-> wrRun == 6'h1a;
	endproperty
	a_saveLen: assert property (p_saveLen) else $error("save burst not 26 words");
	property p_loadLen;
		$fell(nvRd) |-> rdRun == 6'h1a;
	endproperty
	a_loadLen: assert property (p_loadLen) else $error("load burst not 26 words");
	property p_oneWay;
		!(nvWr && nvRd);
	endproperty
	a_oneWay: assert property (p_oneWay) else $error("store read and write together");
	property p_burstStart;
		($rose(nvWr) || $rose(nvRd)) |-> nvAddr[4:0] == 5'h0;
	endproperty
	a_burstStart: assert property (p_burstStart) else $error("burst not at word 0");
	property p_step;
		(nvWr && $past(nvWr)) || (nvRd && $past(nvRd)) |-> nvAddr == $past(nvAddr) + 9'h1;
	endproperty
	a_step: assert property (p_step) else $error("burst address not stepping");
	property p_rdIdle;
		!regRd |=> regRdData == 32'h0;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
	property p_hold;
		pixOutValid && !pixOutReady |=>
			pixOutValid && $stable(correctedLevel) && $stable(pixOutSof);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled pixel changed");
	property p_quiet;
		$rose(rst_b) |-> !pixOutValid && !nvWr && !nvRd && regRdData == 32'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
endmodule

bind flat_field_correction ffc_properties u_props (.mclk, .rst_b, .regRd, .regRdData,
	.pixOutValid, .pixOutReady, .pixOutSof, .correctedLevel, .nvAddr, .nvWr, .nvRd);
`default_nettype wire

/* test/ffc_nv_store.sv */
`default_nettype none
module ffc_nv_store (
	input  wire logic        mclk,
	input  wire logic [8:0]  nvAddr,
	input  wire logic [11:0] nvWrData,
	input  wire logic        nvWr,
	input  wire logic        nvRd,
	output logic      [11:0] nvRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] mem [512];
	logic [11:0] last;
	logic        rdOk;

	// every slot starts as a flat field of 1000 with target 1000
	initial begin
		foreach (mem[i]) mem[i] = 12'h3e8;
		last = 12'h0;
		rdOk = 1'b0;
	end

	// sixteen slots of 26 words, slot in the upper address bits
	always @(posedge mclk) begin
		if (nvWr) mem[nvAddr] <= nvWrData;
		if (nvRd) last <= mem[nvAddr];
		rdOk <= nvRd;
	end

	// data only in the cycle after a read, inverted otherwise
	assign nvRdData = rdOk ? last : ~last;
endmodule
`default_nettype wire

/* test/test_flat_field_correction.sv */
`include "ffc_map.svh"
`default_nettype none
module test_flat_field_correction;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, rst_b, regWr, regRd, pixInValid, pixInReady, pixInSof;
	logic        pixOutValid, pixOutReady, pixOutSof, nvWr, nvRd, rdPend;
	logic [7:0]  regAddr;
	logic [8:0]  nvAddr;
	logic [11:0] rawLevel, correctedLevel, nvWrData, nvRdData;
	logic [12:0] curExp;
	logic [31:0] regWrData, regRdData, seed;
	logic [31:0] oSeed = 32'h139f7;
	logic [12:0] pixQ [$];
	logic [31:0] rdQ [$];
	int          bad_count, compares;

	flat_field_correction #(.IMG_W(64), .IMG_H(64), .CELL_SH(4), .FIFO_D(4)) u_dut (
		.mclk, .rst_b, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
		.pixInValid, .pixInReady, .pixInSof, .rawLevel, .pixOutValid, .pixOutReady,
		.pixOutSof, .correctedLevel, .nvAddr, .nvWrData, .nvWr, .nvRd, .nvRdData);
	ffc_nv_store u_nv (.mclk, .nvAddr, .nvWrData, .nvWr, .nvRd, .nvRdData);

	// ----
	// helpers
	// ----
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("compares=%0d bad=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge mclk);
		regWr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		regRd <= 1'b1;
		regAddr <= a;
		rdQ.push_back(e);
		@(posedge mclk);
		regRd <= 1'b0;
		@(posedge mclk);
	endtask

	// lvl below zero means random levels; f zero means pass-through expected
	task automatic pix(input int n, input int lvl, input int t, input int f);
		logic [11:0] r;
		logic        rdy;
		int          x;
		for (int i = 0; i < n; i++) begin
			seed = lfsr(seed);
			r = (lvl < 0) ? seed[11:0] : lvl[11:0];
			x = (f == 0) ? r : r * t / f;
			pixInValid <= 1'b1;
			pixInSof <= (i == 0);
			rawLevel <= r;
			curExp <= {i == 0, (x > 4095) ? 12'hfff : x[11:0]};
			do begin
				@(negedge mclk);
				rdy = pixInReady;
				@(posedge mclk);
			end while (!rdy);
		end
		pixInValid <= 1'b0;
		pixInSof <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic drain;
		int k;
		k = 0;
		while (pixQ.size() != 0 && k < 3000) begin
			@(posedge mclk);
			k++;
		end
		if (k == 3000) bad_count++;
		repeat (10) @(posedge mclk);
	endtask

	task automatic resetDut;
		rst_b <= 1'b0;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
	endtask

	// clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// notes taken pixels, compares delivered pixels and read data, stalls output
	always @(posedge mclk) begin
		if (rst_b && pixInValid && pixInReady) pixQ.push_back(curExp);
		if (rst_b && pixOutValid && pixOutReady) begin
			if (pixQ.size() == 0) chk(32'h1, 32'h0);
			else chk({19'h0, pixOutSof, correctedLevel}, {19'h0, pixQ.pop_front()});
		end
		if (rdPend) chk(regRdData, rdQ.pop_front());
		rdPend <= rst_b && regRd;
		oSeed = lfsr(oSeed);
		pixOutReady <= oSeed[0] | oSeed[1];
	end

	// watchdog, about five times the expected run
	initial begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		complete_run();
	end

	// main sequence
	initial begin
		{rst_b, regWr, regRd, pixInValid, pixInSof} = 5'h0;
		{regAddr, regWrData, rawLevel, curExp} = 65'h0;
		seed = 32'h139f7;
		bad_count = 0;
		compares = 0;
		@(posedge mclk);
		resetDut();
		rd(`FFC_REG_CTRL, 32'h0);
		rd(`FFC_REG_SLOT, 32'h0);
		rd(`FFC_REG_TARGET, 32'hfff);
		rd(`FFC_REG_STATUS, 32'h0);
		rd(8'h1c, 32'h0);
		pix(64, -1, 0, 0);
		drain();
		$display("test bypass done");
		for (int i = 0; i < 16; i++) begin
			wr(`FFC_REG_SLOT, 32'((i + 4) & 15));
			repeat (40) @(posedge mclk);
			rd(`FFC_REG_SLOT, 32'((i + 4) & 15));
		end
		rd(`FFC_REG_TARGET, 32'h3e8);
		$display("test slots done");
		wr(`FFC_REG_GEN, 32'h7d0);
		wr(`FFC_REG_SLOT, 32'h5);
		rd(`FFC_REG_SLOT, 32'h3);
		rd(`FFC_REG_STATUS, 32'h3);
		pix(4096, 1000, 0, 0);
		drain();
		rd(`FFC_REG_STATUS, 32'h4);
		rd(`FFC_REG_TARGET, 32'h7d0);
		wr(`FFC_REG_CTRL, 32'h1);
		pix(300, -1, 2000, 1000);
		drain();
		wr(`FFC_REG_SAVE, 32'h0);
		repeat (40) @(posedge mclk);
		rd(`FFC_REG_STATUS, 32'h0);
		$display("test manual done");
		wr(`FFC_REG_CTRL, 32'h0);
		wr(`FFC_REG_GEN, 32'h0);
		pix(4096, 1000, 0, 0);
		drain();
		rd(`FFC_REG_TARGET, 32'h3e8);
		wr(`FFC_REG_LOAD, 32'h0);
		repeat (40) @(posedge mclk);
		rd(`FFC_REG_TARGET, 32'h7d0);
		wr(`FFC_REG_CTRL, 32'h1);
		pix(100, -1, 2000, 1000);
		drain();
		$display("test reject done");
		resetDut();
		rd(`FFC_REG_TARGET, 32'hfff);
		wr(`FFC_REG_SLOT, 32'h3);
		repeat (40) @(posedge mclk);
		rd(`FFC_REG_TARGET, 32'h7d0);
		wr(`FFC_REG_CTRL, 32'h1);
		pix(100, -1, 2000, 1000);
		drain();
		$display("test reload done");
		complete_run();
	end
endmodule
`default_nettype wire
